// >>> led_policy_pkg.sv
// Package: constants, register layouts and blink rate table of the LED blink policy block
// Overview of operation
// - Collision uses mode 2 if selected, else 1
// - Duty reverse swaps the ON and OFF portions
// - Loopback mute stops blinking during internal loopback
// - Jabber mute stops blinking during 10 Mb/s jabber
// - Level enable: heavy traffic mode 0, else 1
// - Heavy: active time above threshold times 42 ms
// - Receive and transmit activity measured by separate accumulators
// - Mode 0 rate chosen by bits 15:12
// - Codes 0 to 5 give slow blinks
// - Codes 6, 7, 9 give 4/3/1 s blinks
// - Codes 10, 12 to 15 give square waves
// - Mode 1 rate chosen by bits 11:8
// - Mode 2 rate chosen by bits 7:4
// - Collision blink needs link, collision and LED enable
package led_policy_pkg;
   // Register map
   localparam logic [15:0] COMMON_ADDR = 16'h40c1;
   localparam logic [15:0] RATE_ADDR = 16'h40c2;
   localparam logic [15:0] STATUS_ADDR = 16'h40d0;
   localparam logic [15:0] COMMON_RESET = 16'h00cc;
   localparam logic [15:0] RATE_RESET = 16'hec75;
   localparam int NUM_LEDS_DEF = 2;
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS = 1000000;
   localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam int INTERVAL_S = 1;
   localparam int INTERVAL_MS = INTERVAL_S * 1000;
   localparam int THRESH_STEP_MS = 42;
   localparam int PCT_FULL = 100;
   localparam int RATE_CODES = 16;
   // Period of each rate code in ms; the 2.5 Hz code is 400 ms
   localparam logic [13:0] PERIOD_MS [RATE_CODES] = '{
      14'h2710, 14'h24b8, 14'h1f40, 14'h1ce8, 14'h1770, 14'h1388, 14'h0fa0, 14'h0bb8,
      14'h07d0, 14'h03e8, 14'h01f4, 14'h0190, 14'h014d, 14'h00a7, 14'h007d, 14'h0064};
   // OFF share of each period in percent, unreversed duty
   localparam logic [6:0] OFF_PCT [RATE_CODES] = '{
      7'h06, 7'h07, 7'h08, 7'h09, 7'h0b, 7'h06, 7'h08, 7'h0b,
      7'h0b, 7'h10, 7'h32, 7'h32, 7'h32, 7'h32, 7'h32, 7'h32};

   typedef struct packed {
      logic [5:0] rsvd;
      logic reverse_duty;
      logic loopback_indicator_mute;
      logic jabber_indicator_mute;
      logic col_fast_sel;
      logic act_level_en;
      logic [4:0] heavy_traffic_threshold;
   } indicator_common_config_s;

   typedef struct packed {
      logic [3:0] mode0_sel;
      logic [3:0] mode1_sel;
      logic [3:0] mode2_sel;
      logic [3:0] mode3_sel;
   } indicator_rate_config_s;

   typedef struct packed {
      logic [11:0] rsvd;
      logic mute;
      logic tx_heavy;
      logic rx_heavy;
      logic heavy;
   } indicator_status_s;

   typedef enum logic [1:0] {SRC_NONE, SRC_MODE0, SRC_MODE1, SRC_MODE2} blink_src_e;

   // Length of the lit part of a period in ms
   function automatic logic [13:0] on_ms(input logic [3:0] code);
      int p;
      p = int'(PERIOD_MS[code]);
      return 14'(p - (p * int'(OFF_PCT[code])) / PCT_FULL);
   endfunction
endpackage

// >>> blink_pattern.sv
// Blink pattern generator: one ON/OFF waveform for one blink mode
module blink_pattern (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Timebase and configuration
   input wire logic ms_tick,
   input wire logic [3:0] rate_sel,
   input wire logic reverse_duty,
   // Waveform
   output logic led_on
);
   typedef struct packed {
      logic [13:0] cnt;
      logic on;
   } state_s;

   state_s st_q;
   state_s st_d;
   logic [13:0] period;
   logic [13:0] lit;

   always_comb begin
      period = led_policy_pkg::PERIOD_MS[rate_sel];
      lit = led_policy_pkg::on_ms(rate_sel);
      st_d = st_q;
      // A rate change that shortens the period wraps at the next tick
      if (ms_tick) begin
         if (st_q.cnt >= period - 14'h0001) begin
            st_d.cnt = '0;
         end else begin
            st_d.cnt = st_q.cnt + 14'h0001;
         end
      end
      st_d.on = reverse_duty ? (st_q.cnt >= lit) : (st_q.cnt < lit);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign led_on = st_q.on;

   property p_period_wrap;
      @(posedge clk) disable iff (!arst_n)
      (ms_tick && st_q.cnt >= period - 14'h0001) |=> (st_q.cnt == 14'h0000);
   endproperty
   a_period_wrap: assert property (p_period_wrap) else $error("blink counter did not wrap");

   property p_duty_start;
      @(posedge clk) disable iff (!arst_n)
      (st_q.cnt == 14'h0000) |=> (st_q.on == !$past(reverse_duty));
   endproperty
   a_duty_start: assert property (p_duty_start) else $error("period start has wrong level");
endmodule

// >>> activity_meter.sv
// Activity meter: active milliseconds of one path per interval against a threshold
module activity_meter (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Timebase
   input wire logic ms_tick,
   input wire logic win_end,
   // Path activity and threshold
   input wire logic active,
   input wire logic [4:0] threshold,
   // Verdict of the last finished interval
   output logic heavy
);
   typedef struct packed {
      logic seen;
      logic [10:0] acc;
      logic heavy;
   } state_s;

   localparam logic [10:0] STEP_MS = 11'(led_policy_pkg::THRESH_STEP_MS);

   state_s st_q;
   state_s st_d;
   logic [10:0] sum;
   logic [10:0] limit;

   always_comb begin
      st_d = st_q;
      // Any activity inside a millisecond counts that millisecond as active
      sum = st_q.acc + {10'h000, st_q.seen | active};
      limit = 11'(threshold) * STEP_MS;
      st_d.seen = st_q.seen | active;
      if (ms_tick) begin
         st_d.seen = 1'b0;
         st_d.acc = sum;
         if (win_end) begin
            st_d.heavy = sum > limit;
            st_d.acc = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign heavy = st_q.heavy;

   property p_verdict;
      @(posedge clk) disable iff (!arst_n)
      (ms_tick && win_end) |=> (heavy == ($past(sum) > $past(limit)));
   endproperty
   a_verdict: assert property (p_verdict) else $error("heavy verdict wrong");
endmodule

// >>> led_blink_policy_control.sv
// LED blink policy: common LED configuration, rate generation and heavy traffic detection
//
// The plain strobed port is this design's own decision.
module led_blink_policy_control #(
   parameter int NUM_LEDS = led_policy_pkg::NUM_LEDS_DEF,
   parameter int CYCLES_PER_MS = led_policy_pkg::CYCLES_PER_MS,
   parameter int INTERVAL_MS = led_policy_pkg::INTERVAL_MS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // PHY status
   input wire logic link_up,
   input wire logic collision,
   input wire logic loopback_active,
   input wire logic jabber_active,
   input wire logic rx_active,
   input wire logic tx_active,
   input wire logic [NUM_LEDS-1:0] col_blink_en,
   // Blink waveforms and decisions
   output logic [2:0] mode_pattern,
   output logic activity_on,
   output led_policy_pkg::blink_src_e activity_src,
   output logic [NUM_LEDS-1:0] collision_on,
   output led_policy_pkg::blink_src_e collision_src,
   output logic blink_mute,
   output logic traffic_heavy,
   output logic [3:0] mode3_rate_sel
);
   localparam int PW = $clog2(CYCLES_PER_MS);
   localparam int WW = $clog2(INTERVAL_MS);
   localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_MS - 1);
   localparam logic [WW-1:0] WIN_LAST = WW'(INTERVAL_MS - 1);

   generate
      if (NUM_LEDS < 1 || CYCLES_PER_MS < 2 || INTERVAL_MS < 2 || INTERVAL_MS > 2047) begin : g_bad
         $error("led_blink_policy_control: unsupported parameter values");
      end
   endgenerate

   typedef struct packed {
      led_policy_pkg::indicator_common_config_s common;
      led_policy_pkg::indicator_rate_config_s rates;
      logic [PW-1:0] pre;
      logic ms_tick;
      logic [WW-1:0] win;
      logic win_end;
      logic [15:0] rdata;
      logic [2:0] pat;
      logic mute;
      logic heavy;
      led_policy_pkg::blink_src_e act_src;
      logic act_on;
      led_policy_pkg::blink_src_e col_src;
      logic [NUM_LEDS-1:0] col_on;
   } state_s;

   state_s st_q;
   state_s st_d;
   logic [2:0] gen_on;
   logic rx_heavy;
   logic tx_heavy;
   logic activity_now;
   led_policy_pkg::indicator_status_s status;

   function automatic logic pick(input led_policy_pkg::blink_src_e s, input logic [2:0] p);
      logic r;
      r = 1'b0;
      case (s)
         led_policy_pkg::SRC_MODE0: r = p[0];
         led_policy_pkg::SRC_MODE1: r = p[1];
         led_policy_pkg::SRC_MODE2: r = p[2];
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // One waveform for each of blink modes 0 to 2, all on the shared rate table; mode 3 has none
   blink_pattern u_mode0 (
      .clk(clk),
      .arst_n(arst_n),
      .ms_tick(st_q.ms_tick),
      .rate_sel(st_q.rates.mode0_sel),
      .reverse_duty(st_q.common.reverse_duty),
      .led_on(gen_on[0])
   );

   blink_pattern u_mode1 (
      .clk(clk),
      .arst_n(arst_n),
      .ms_tick(st_q.ms_tick),
      .rate_sel(st_q.rates.mode1_sel),
      .reverse_duty(st_q.common.reverse_duty),
      .led_on(gen_on[1])
   );

   blink_pattern u_mode2 (
      .clk(clk),
      .arst_n(arst_n),
      .ms_tick(st_q.ms_tick),
      .rate_sel(st_q.rates.mode2_sel),
      .reverse_duty(st_q.common.reverse_duty),
      .led_on(gen_on[2])
   );

   // Separate meters, so a busy receive path cannot hide behind an idle transmit path
   activity_meter u_rx_meter (
      .clk(clk),
      .arst_n(arst_n),
      .ms_tick(st_q.ms_tick),
      .win_end(st_q.win_end),
      .active(rx_active),
      .threshold(st_q.common.heavy_traffic_threshold),
      .heavy(rx_heavy)
   );

   activity_meter u_tx_meter (
      .clk(clk),
      .arst_n(arst_n),
      .ms_tick(st_q.ms_tick),
      .win_end(st_q.win_end),
      .active(tx_active),
      .threshold(st_q.common.heavy_traffic_threshold),
      .heavy(tx_heavy)
   );

   always_comb begin
      st_d = st_q;
      status = '0;
      st_d.ms_tick = 1'b0;
      st_d.win_end = 1'b0;
      st_d.rdata = '0;

      // Millisecond timebase and one second interval, both pulses in the same cycle
      if (st_q.pre == PRE_LAST) begin
         st_d.pre = '0;
         st_d.ms_tick = 1'b1;
         if (st_q.win == WIN_LAST) begin
            st_d.win = '0;
            st_d.win_end = 1'b1;
         end else begin
            st_d.win = st_q.win + WW'(1);
         end
      end else begin
         st_d.pre = st_q.pre + PW'(1);
      end

      // Register writes; reserved bits of the common register stay zero
      if (reg_wr) begin
         case (reg_addr)
            led_policy_pkg::COMMON_ADDR: begin
               st_d.common = led_policy_pkg::indicator_common_config_s'(reg_wdata);
               st_d.common.rsvd = '0;
            end
            led_policy_pkg::RATE_ADDR: begin
               st_d.rates = led_policy_pkg::indicator_rate_config_s'(reg_wdata);
            end
            default: begin
            end
         endcase
      end

      status.mute = st_q.mute;
      status.tx_heavy = tx_heavy;
      status.rx_heavy = rx_heavy;
      status.heavy = st_q.heavy;

      // Read data stands for one cycle only; unmapped addresses read zero
      if (reg_rd) begin
         case (reg_addr)
            led_policy_pkg::COMMON_ADDR: st_d.rdata = st_q.common;
            led_policy_pkg::RATE_ADDR: st_d.rdata = st_q.rates;
            led_policy_pkg::STATUS_ADDR: st_d.rdata = status;
            default: st_d.rdata = '0;
         endcase
      end

      st_d.pat = gen_on;
      st_d.heavy = rx_heavy | tx_heavy;

      st_d.mute = (loopback_active & st_q.common.loopback_indicator_mute)
         | (jabber_active & st_q.common.jabber_indicator_mute);

      // Activity blink follows traffic weight only when the level mode is enabled
      if (!activity_now) begin
         st_d.act_src = led_policy_pkg::SRC_NONE;
      end else if (st_q.common.act_level_en && st_q.heavy) begin
         st_d.act_src = led_policy_pkg::SRC_MODE0;
      end else begin
         st_d.act_src = led_policy_pkg::SRC_MODE1;
      end
      st_d.act_on = !st_d.mute && pick(st_d.act_src, st_q.pat);

      st_d.col_src = st_q.common.col_fast_sel ? led_policy_pkg::SRC_MODE2
         : led_policy_pkg::SRC_MODE1;
      for (int i = 0; i < NUM_LEDS; i++) begin
         st_d.col_on[i] = link_up && collision && col_blink_en[i]
            && !st_d.mute && pick(st_d.col_src, st_q.pat);
      end
   end

   assign activity_now = link_up & (rx_active | tx_active);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
         st_q.common <= led_policy_pkg::COMMON_RESET;
         st_q.rates <= led_policy_pkg::RATE_RESET;
         st_q.col_src <= led_policy_pkg::SRC_MODE2;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign mode_pattern = st_q.pat;
   assign activity_on = st_q.act_on;
   assign activity_src = st_q.act_src;
   assign collision_on = st_q.col_on;
   assign collision_src = st_q.col_src;
   assign blink_mute = st_q.mute;
   assign traffic_heavy = st_q.heavy;
   assign mode3_rate_sel = st_q.rates.mode3_sel;

   property p_col_select;
      @(posedge clk) disable iff (!arst_n)
      (reg_wr && reg_addr == led_policy_pkg::COMMON_ADDR) |=> ##1
         (collision_src == ($past(reg_wdata[6], 2) ? led_policy_pkg::SRC_MODE2
         : led_policy_pkg::SRC_MODE1));
   endproperty
   a_col_select: assert property (p_col_select) else $error("collision mode wrong");

   property p_loopback_mute;
      @(posedge clk) disable iff (!arst_n)
      (loopback_active && st_q.common.loopback_indicator_mute)
         |=> (blink_mute && !activity_on && collision_on == '0);
   endproperty
   a_loopback_mute: assert property (p_loopback_mute) else $error("blink in loopback");

   property p_jabber_mute;
      @(posedge clk) disable iff (!arst_n)
      (jabber_active && st_q.common.jabber_indicator_mute)
         |=> (blink_mute && !activity_on && collision_on == '0);
   endproperty
   a_jabber_mute: assert property (p_jabber_mute) else $error("blink in jabber");

   property p_no_mute;
      @(posedge clk) disable iff (!arst_n)
      (!loopback_active && !jabber_active) |=> !blink_mute;
   endproperty
   a_no_mute: assert property (p_no_mute) else $error("mute without cause");

   property p_level_off;
      @(posedge clk) disable iff (!arst_n)
      (activity_now && !st_q.common.act_level_en) |=> (activity_src == led_policy_pkg::SRC_MODE1);
   endproperty
   a_level_off: assert property (p_level_off) else $error("activity mode not 1");

   property p_level_on;
      @(posedge clk) disable iff (!arst_n)
      (activity_now && st_q.common.act_level_en && st_q.heavy)
         |=> (activity_src == led_policy_pkg::SRC_MODE0);
   endproperty
   a_level_on: assert property (p_level_on) else $error("heavy traffic not mode 0");

   property p_col_cause;
      @(posedge clk) disable iff (!arst_n)
      collision_on[0] |-> $past(link_up && collision && col_blink_en[0]);
   endproperty
   a_col_cause: assert property (p_col_cause) else $error("collision blink without cause");

   property p_heavy_either;
      @(posedge clk) disable iff (!arst_n)
      (rx_heavy || tx_heavy) |=> traffic_heavy;
   endproperty
   a_heavy_either: assert property (p_heavy_either) else $error("one path heavy ignored");

   property p_interval;
      @(posedge clk) disable iff (!arst_n)
      st_q.win_end |-> (st_q.ms_tick && st_q.win == '0);
   endproperty
   a_interval: assert property (p_interval) else $error("interval end misplaced");

   property p_tick_gap;
      @(posedge clk) disable iff (!arst_n)
      st_q.ms_tick |=> !st_q.ms_tick [*1] ##0 (st_q.pre == PW'(1));
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("millisecond tick spacing wrong");

   property p_read_common;
      @(posedge clk) disable iff (!arst_n)
      (reg_rd && reg_addr == led_policy_pkg::COMMON_ADDR) |=> (reg_rdata == $past(st_q.common));
   endproperty
   a_read_common: assert property (p_read_common) else $error("common readback wrong");

   property p_read_rate;
      @(posedge clk) disable iff (!arst_n)
      (reg_rd && reg_addr == led_policy_pkg::RATE_ADDR) |=> (reg_rdata == $past(st_q.rates));
   endproperty
   a_read_rate: assert property (p_read_rate) else $error("rate readback wrong");

   property p_read_status;
      @(posedge clk) disable iff (!arst_n)
      (reg_rd && reg_addr == led_policy_pkg::STATUS_ADDR) |=> (reg_rdata == {12'h000,
         $past(blink_mute), $past(tx_heavy), $past(rx_heavy), $past(traffic_heavy)});
   endproperty
   a_read_status: assert property (p_read_status) else $error("status readback wrong");

   property p_write_common;
      @(posedge clk) disable iff (!arst_n)
      (reg_wr && reg_addr == led_policy_pkg::COMMON_ADDR)
         |=> (st_q.common == {6'h00, $past(reg_wdata[9:0])});
   endproperty
   a_write_common: assert property (p_write_common) else $error("common write lost");

   property p_write_rate;
      @(posedge clk) disable iff (!arst_n)
      (reg_wr && reg_addr == led_policy_pkg::RATE_ADDR) |=> (st_q.rates == $past(reg_wdata));
   endproperty
   a_write_rate: assert property (p_write_rate) else $error("rate write lost");

   property p_col_link;
      @(posedge clk) disable iff (!arst_n)
      !link_up |=> (collision_on == '0);
   endproperty
   a_col_link: assert property (p_col_link) else $error("blink without link");

   // The mode chosen for collisions is the one whose waveform reaches the LED
   property p_col_mode;
      @(posedge clk) disable iff (!arst_n)
      collision_on[0] |-> (collision_src == led_policy_pkg::SRC_MODE2 ? $past(mode_pattern[2])
         : $past(mode_pattern[1]));
   endproperty
   a_col_mode: assert property (p_col_mode) else $error("collision waveform wrong");

   property p_act_idle;
      @(posedge clk) disable iff (!arst_n)
      !activity_now |=> (activity_src == led_policy_pkg::SRC_NONE && !activity_on);
   endproperty
   a_act_idle: assert property (p_act_idle) else $error("activity blink while idle");

   property p_heavy_none;
      @(posedge clk) disable iff (!arst_n)
      (!rx_heavy && !tx_heavy) |=> !traffic_heavy;
   endproperty
   a_heavy_none: assert property (p_heavy_none) else $error("heavy without cause");
endmodule

// >>> status_led_model.sv
// Status LED model: accumulates the lit time of each LED line driven by the block
module status_led_model #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Window control and LED lines
   input wire logic clr,
   input wire logic [W-1:0] lit,
   // Lit cycles since the last clear
   output logic [15:0] lit_cnt [W]
);
   timeunit 1ns;
   timeprecision 1ps;

   // An LED only shows what is sampled on the clock, so cycles stand in for light time
   always_ff @(posedge clk or negedge arst_n) begin
      for (int i = 0; i < W; i++) begin
         if (!arst_n) begin
            lit_cnt[i] <= 16'h0000;
         end else if (clr) begin
            lit_cnt[i] <= 16'h0000;
         end else begin
            lit_cnt[i] <= lit_cnt[i] + 16'(lit[i]);
         end
      end
   end
endmodule

// >>> testbench.sv
// Testbench: register access, blink rates, duty reverse, muting, collision and heavy traffic
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int CPM = 2;
   localparam int IVL = 100;
   // Periods and lit times in ms of codes 9 to 15
   localparam int PER [7] = '{1000, 500, 400, 333, 167, 125, 100};
   localparam int ON [7] = '{840, 250, 200, 167, 84, 63, 50};

   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic link_up = 1'b0;
   logic collision = 1'b0;
   logic loopback_active = 1'b0;
   logic jabber_active = 1'b0;
   logic rx_active = 1'b0;
   logic tx_active = 1'b0;
   logic [1:0] col_blink_en = 2'b00;
   logic [2:0] mode_pattern;
   logic activity_on;
   led_policy_pkg::blink_src_e activity_src;
   led_policy_pkg::blink_src_e collision_src;
   logic [1:0] collision_on;
   logic blink_mute;
   logic traffic_heavy;
   logic [3:0] mode3_rate_sel;
   logic clr = 1'b0;
   logic [15:0] lit_cnt [6];
   int n_errors = 0;
   int checks = 0;

   always #2.5 clk = ~clk;

   led_blink_policy_control #(.NUM_LEDS(2), .CYCLES_PER_MS(CPM), .INTERVAL_MS(IVL))
      led_blink_policy_control_inst (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .link_up(link_up), .collision(collision), .loopback_active(loopback_active),
      .jabber_active(jabber_active), .rx_active(rx_active), .tx_active(tx_active),
      .col_blink_en(col_blink_en), .mode_pattern(mode_pattern), .activity_on(activity_on),
      .activity_src(activity_src), .collision_on(collision_on),
      .collision_src(collision_src), .blink_mute(blink_mute),
      .traffic_heavy(traffic_heavy), .mode3_rate_sel(mode3_rate_sel));

   // Lines: 1:0 collision LEDs, 2 activity, 5:3 blink modes 0..2
   status_led_model #(.W(6)) status_led_model_inst (.clk(clk), .arst_n(arst_n), .clr(clr),
      .lit({mode_pattern, activity_on, collision_on}), .lit_cnt(lit_cnt));

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", e, reg_rdata)
   endtask

   task automatic wait_ms(input int ms);
      repeat (ms * CPM) @(posedge clk);
      #1;
   endtask

   // Settle for one period so a shortened count has wrapped, then measure one period
   task automatic meas(input int ms);
      wait_ms(ms);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      wait_ms(ms);
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge clk);
      n_errors++;
      end_sim();
   end

   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      // Reset values, reserved bits, unmapped and read-only places
      rd(led_policy_pkg::COMMON_ADDR, 16'h00cc);
      rd(led_policy_pkg::RATE_ADDR, 16'hec75);
      wr(led_policy_pkg::COMMON_ADDR, 16'hffff);
      rd(led_policy_pkg::COMMON_ADDR, 16'h03ff);
      wr(led_policy_pkg::STATUS_ADDR, 16'hffff);
      rd(led_policy_pkg::STATUS_ADDR, 16'h0000);
      rd(16'h40c3, 16'h0000);
      wr(led_policy_pkg::COMMON_ADDR, 16'h00cc);
      rd(led_policy_pkg::RATE_ADDR, 16'hec75);
      // Rate table for the short codes on mode 0
      for (int i = 0; i < 7; i++) begin
         wr(led_policy_pkg::RATE_ADDR, {4'(i + 9), 12'hc75});
         meas(PER[i]);
         `CHK("mode0 lit", 16'(ON[i] * CPM), lit_cnt[3])
      end
      // Duty reverse lights only the former off part
      wr(led_policy_pkg::COMMON_ADDR, 16'h02cc);
      meas(PER[6]);
      `CHK("reversed lit", 16'((PER[6] - ON[6]) * CPM), lit_cnt[3])
      wr(led_policy_pkg::RATE_ADDR, 16'h9f75);
      meas(PER[0]);
      `CHK("reversed lit", 16'((PER[0] - ON[0]) * CPM), lit_cnt[3])
      `CHK("mode1 lit", 16'((PER[0] / PER[6]) * (PER[6] - ON[6]) * CPM), lit_cnt[4])
      wr(led_policy_pkg::COMMON_ADDR, 16'h00cc);
      // Slow codes over one 10 s window: code 5 on mode 0, 8 on mode 1, 9 on mode 2
      wr(led_policy_pkg::RATE_ADDR, 16'h5896);
      meas(10000);
      `CHK("code5 lit", 16'(2 * 4700 * CPM), lit_cnt[3])
      `CHK("code8 lit", 16'(5 * 1780 * CPM), lit_cnt[4])
      `CHK("code9 lit", 16'(10 * ON[0] * CPM), lit_cnt[5])
      `CHK("mode3 sel", 4'h6, mode3_rate_sel)
      // Collision: mode 2 on code 9, mode 1 on code 15, only LED 0 enabled
      wr(led_policy_pkg::RATE_ADDR, 16'hef95);
      link_up <= 1'b1;
      collision <= 1'b1;
      col_blink_en <= 2'b01;
      meas(PER[0]);
      `CHK("col src", led_policy_pkg::SRC_MODE2, collision_src)
      `CHK("col led0", 16'(ON[0] * CPM), lit_cnt[0])
      `CHK("col led1", 16'h0000, lit_cnt[1])
      wr(led_policy_pkg::COMMON_ADDR, 16'h008c);
      meas(PER[6]);
      `CHK("col src", led_policy_pkg::SRC_MODE1, collision_src)
      `CHK("col led0", 16'(ON[6] * CPM), lit_cnt[0])
      @(posedge clk);
      link_up <= 1'b0;
      meas(PER[6]);
      `CHK("col no link", 16'h0000, lit_cnt[0])
      @(posedge clk);
      collision <= 1'b0;
      // Muting by jabber and loopback
      wr(led_policy_pkg::COMMON_ADDR, 16'h00cc);
      link_up <= 1'b1;
      rx_active <= 1'b1;
      jabber_active <= 1'b1;
      wait_ms(1);
      `CHK("jabber mute", 1'b1, blink_mute)
      `CHK("jabber act", 1'b0, activity_on)
      rd(led_policy_pkg::STATUS_ADDR, 16'h0008);
      wr(led_policy_pkg::COMMON_ADDR, 16'h004c);
      wait_ms(1);
      `CHK("jabber free", 1'b0, blink_mute)
      @(posedge clk);
      jabber_active <= 1'b0;
      loopback_active <= 1'b1;
      wait_ms(1);
      `CHK("loop free", 1'b0, blink_mute)
      wr(led_policy_pkg::COMMON_ADDR, 16'h01cc);
      wait_ms(1);
      `CHK("loop mute", 1'b1, blink_mute)
      `CHK("loop act", 1'b0, activity_on)
      @(posedge clk);
      loopback_active <= 1'b0;
      // Heavy traffic: threshold 2 is 84 ms, rx busy all of each 100 ms interval
      wr(led_policy_pkg::COMMON_ADDR, 16'h00e2);
      wait_ms(IVL * 5 / 2);
      `CHK("heavy rx", 1'b1, traffic_heavy)
      `CHK("act src", led_policy_pkg::SRC_MODE0, activity_src)
      rd(led_policy_pkg::STATUS_ADDR, 16'h0003);
      wr(led_policy_pkg::COMMON_ADDR, 16'h00c2);
      wait_ms(1);
      `CHK("act src", led_policy_pkg::SRC_MODE1, activity_src)
      // Threshold 3 is 126 ms, more than an interval can hold
      wr(led_policy_pkg::COMMON_ADDR, 16'h00e3);
      wait_ms(IVL * 5 / 2);
      `CHK("light rx", 1'b0, traffic_heavy)
      `CHK("act src", led_policy_pkg::SRC_MODE1, activity_src)
      wr(led_policy_pkg::COMMON_ADDR, 16'h00e2);
      rx_active <= 1'b0;
      tx_active <= 1'b1;
      wait_ms(IVL * 5 / 2);
      rd(led_policy_pkg::STATUS_ADDR, 16'h0005);
      @(posedge clk);
      tx_active <= 1'b0;
      wait_ms(IVL * 5 / 2);
      `CHK("idle", 1'b0, traffic_heavy)
      `CHK("act src", led_policy_pkg::SRC_NONE, activity_src)
      // Reset in mid-run brings both registers back to their defaults
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      rd(led_policy_pkg::COMMON_ADDR, 16'h00cc);
      rd(led_policy_pkg::RATE_ADDR, 16'hec75);
      `CHK("mode3 sel", 4'h5, mode3_rate_sel)
      end_sim();
   end
endmodule
